/* align_pkg.sv */
// Purpose: Shared constants and types for the delay alignment stage
// Assumes: 20 MHz pclk, 16 kHz samples arriving as a valid/ready stream
// Notes:   Register offsets are byte addresses on APB
package align_pkg;
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned SAMPLE_HZ   = 16_000;
  localparam int unsigned MAX_CORR_MS = 150;
  localparam int unsigned DLY_DEPTH   = MAX_CORR_MS * SAMPLE_HZ / 1000;
  localparam logic [11:0] DLY_MAX     = 12'(DLY_DEPTH - 1);
  localparam logic [11:0] DLY_WRAP    = 12'(DLY_DEPTH);
  localparam logic [12:0] EST_OFFSET  = 13'(DLY_DEPTH);
  localparam logic [12:0] EST_MAX     = 13'h1C20;
  localparam int unsigned EST_TIME_S  = 5;
  localparam int unsigned EST_CYC     = EST_TIME_S * CLK_HZ;
  localparam logic [15:0] REF_LEVEL   = 16'h0100;

  // Register offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_LEN      = 8'h04;
  localparam logic [7:0] OFF_DIR      = 8'h08;
  localparam logic [7:0] OFF_ADAPT    = 8'h0C;
  localparam logic [7:0] OFF_STATUS   = 8'h10;
  localparam logic [7:0] OFF_EST      = 8'h14;

  // Control bit positions
  localparam int unsigned CTRL_AUTO   = 0;
  localparam int unsigned CTRL_START  = 1;
  localparam int unsigned CTRL_FORCE  = 2;
  localparam int unsigned CTRL_CFG    = 3;

  // Values after reset; ADAPT_AUTO is the adaptation value while automatic
  localparam logic        AUTO_RST    = 1'b0;
  localparam logic        START_RST   = 1'b1;
  localparam logic        DIR_RST     = 1'b0;
  localparam logic [11:0] LEN_RST     = 12'h000;
  localparam logic [1:0]  ADAPT_RST   = 2'h0;
  localparam logic [1:0]  ADAPT_AUTO  = 2'h0;

  typedef struct packed {
    logic [15:0] ref_s;
    logic [15:0] mic_s;
  } pair_s;

  typedef enum logic [2:0] {ST_IDLE, ST_EST, ST_APPLY, ST_RESTART} est_e;
endpackage

/* auto_delay_alignment.sv */
// Purpose: Delay alignment ahead of the echo canceller, with APB control
// Assumes: One clock domain; echo canceller reports its estimate on ec_est
// Notes:   Changing the delay length mid-stream causes one discontinuity
`timescale 1ns/1ps
module auto_delay_alignment
  import align_pkg::*;
#(
  parameter int unsigned EST_TIMEOUT_CYC = align_pkg::EST_CYC
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Sample stream in
  input  wire logic             in_valid,
  input  wire align_pkg::pair_s in_pair,
  output logic                  in_ready,
  // Aligned stream out
  output logic                  out_valid,
  output align_pkg::pair_s      out_pair,
  input  wire logic             out_ready,
  // System status
  input  wire logic             host_cfg_change,
  input  wire logic             spk_playing,
  // Echo canceller link
  input  wire logic             ec_est_valid,
  input  wire logic [12:0]      ec_est,
  input  wire logic             ec_est_done,
  output logic                  ec_cancel_en,
  output logic                  ec_restart,
  output logic [1:0]            ec_adapt_cfg
);
  import align_pkg::*;

  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        auto_en_ff;
  logic        start_en_ff;
  logic [11:0] len_ff;
  logic        dir_ff;
  logic [1:0]  adapt_ff;
  logic [12:0] est_ff;
  logic        active_ff;
  logic        boot_ff;
  logic        cfg_pend_ff;
  logic        force_pend_ff;
  logic        ref_ok_ff;
  logic        cancel_ff;
  logic        restart_ff;
  logic [1:0]  ec_adapt_ff;
  logic [31:0] timer_ff;
  est_e        state_ff;
  est_e        nxt_state;

  // Bus decode
  logic        acc;
  logic        wr;
  logic        mapped;
  logic [31:0] rd_data;
  assign acc = psel & penable & ~pready_ff;
  assign wr  = psel & penable & pwrite & pready_ff;

  always_comb begin
    mapped  = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      OFF_CTRL: begin
        rd_data[CTRL_AUTO]  = auto_en_ff;
        rd_data[CTRL_START] = start_en_ff;
      end
      OFF_LEN:    rd_data[11:0] = len_ff;
      OFF_DIR:    rd_data[0] = dir_ff;
      OFF_ADAPT:  rd_data[1:0] = adapt_ff;
      OFF_STATUS: rd_data[0] = active_ff;
      OFF_EST:    rd_data[12:0] = active_ff ? est_ff : 13'h0000;
      default:    mapped = 1'b0;
    endcase
  end

  // One wait state: data is registered on the same edge that raises pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= acc;
      pslverr_ff <= acc & ~mapped;
      if (acc) begin
        prdata_ff <= rd_data;
      end
    end
  end

  logic wr_ctrl;
  logic wr_force;
  logic wr_cfg;
  assign wr_ctrl  = wr & (paddr == OFF_CTRL);
  assign wr_force = wr_ctrl & pwdata[CTRL_FORCE];
  assign wr_cfg   = wr_ctrl & pwdata[CTRL_CFG];

  // Control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_en_ff  <= AUTO_RST;
      start_en_ff <= START_RST;
    end else if (wr_ctrl) begin
      auto_en_ff  <= pwdata[CTRL_AUTO];
      start_en_ff <= pwdata[CTRL_START];
    end
  end

  // Apply result: estimate minus offset gives signed lag
  logic [12:0] lag_pos;
  logic [12:0] lag_neg;
  assign lag_pos = est_ff - EST_OFFSET;
  assign lag_neg = EST_OFFSET - est_ff;

  // Length and direction; the device wins while automatic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_ff <= LEN_RST;
      dir_ff <= DIR_RST;
    end else if (state_ff == ST_APPLY) begin
      if (est_ff >= EST_OFFSET) begin
        dir_ff <= 1'b0;
        len_ff <= (lag_pos > 13'(DLY_MAX)) ? DLY_MAX : lag_pos[11:0];
      end else begin
        dir_ff <= 1'b1;
        len_ff <= (lag_neg > 13'(DLY_MAX)) ? DLY_MAX : lag_neg[11:0];
      end
    end else if (wr && !auto_en_ff) begin
      if (paddr == OFF_LEN) begin
        len_ff <= (pwdata > 32'(DLY_MAX)) ? DLY_MAX : pwdata[11:0];
      end
      if (paddr == OFF_DIR) begin
        dir_ff <= pwdata[0];
      end
    end
  end

  // Host adaptation value is kept for reads even when overridden
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adapt_ff    <= ADAPT_RST;
      ec_adapt_ff <= ADAPT_RST;
    end else begin
      if (wr && paddr == OFF_ADAPT) begin
        adapt_ff <= pwdata[1:0];
      end
      ec_adapt_ff <= auto_en_ff ? ADAPT_AUTO : adapt_ff;
    end
  end

  // Estimate capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      est_ff <= 13'h0000;
    end else if (state_ff == ST_EST && ec_est_valid) begin
      est_ff <= (ec_est > EST_MAX) ? EST_MAX : ec_est;
    end
  end

  // Start requests; a new event beats the clear at start
  logic start_go;
  logic gate_ok;
  assign gate_ok  = ref_ok_ff & spk_playing;
  assign start_go = (state_ff == ST_IDLE) && (nxt_state == ST_EST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_ff       <= 1'b1;
      cfg_pend_ff   <= 1'b0;
      force_pend_ff <= 1'b0;
    end else begin
      if (start_go) begin
        boot_ff <= 1'b0;
      end
      if ((host_cfg_change && auto_en_ff) || wr_cfg) begin
        cfg_pend_ff <= 1'b1;
      end else if (start_go) begin
        cfg_pend_ff <= 1'b0;
      end
      if (wr_force) begin
        force_pend_ff <= 1'b1;
      end else if (start_go) begin
        force_pend_ff <= 1'b0;
      end
    end
  end

  // Estimation sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (force_pend_ff) begin
          nxt_state = ST_EST;
        end else if (((boot_ff && start_en_ff) || cfg_pend_ff) && gate_ok) begin
          nxt_state = ST_EST;
        end
      end
      ST_EST: begin
        if (ec_est_done) begin
          nxt_state = ST_APPLY;
        end else if (timer_ff >= EST_TIMEOUT_CYC - 1) begin
          nxt_state = ST_RESTART;
        end
      end
      ST_APPLY:   nxt_state = ST_RESTART;
      ST_RESTART: nxt_state = ST_IDLE;
      default:    nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= ST_IDLE;
      active_ff  <= 1'b0;
      cancel_ff  <= 1'b1;
      restart_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      active_ff  <= (nxt_state != ST_IDLE);
      cancel_ff  <= (nxt_state == ST_IDLE);
      restart_ff <= (nxt_state == ST_RESTART);
    end
  end

  // Timeout guards a canceller that never reports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ff <= 32'h0000_0000;
    end else if (state_ff == ST_EST) begin
      timer_ff <= timer_ff + 32'h0000_0001;
    end else begin
      timer_ff <= 32'h0000_0000;
    end
  end

  // Reference energy: last accepted sample at or above level
  logic [15:0] ref_mag;
  assign ref_mag = in_pair.ref_s[15] ? 16'(-in_pair.ref_s) : in_pair.ref_s;

  logic take;
  assign take = in_valid & in_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ok_ff <= 1'b0;
    end else if (take) begin
      ref_ok_ff <= (ref_mag >= REF_LEVEL);
    end
  end

  // Delay line for the selected channel
  logic [15:0] mem [DLY_DEPTH];
  logic [11:0] wptr_ff;
  logic [11:0] raddr;
  logic [15:0] rd_ff;
  logic [15:0] wsel;
  assign wsel  = dir_ff ? in_pair.mic_s : in_pair.ref_s;
  assign raddr = (wptr_ff >= len_ff) ? wptr_ff - len_ff : wptr_ff + DLY_WRAP - len_ff;

  // Read before write, so length zero is bypassed downstream
  always_ff @(posedge pclk) begin
    if (take) begin
      mem[wptr_ff] <= wsel;
      rd_ff        <= mem[raddr];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_ff <= 12'h000;
    end else if (take) begin
      wptr_ff <= (wptr_ff == DLY_MAX) ? 12'h000 : wptr_ff + 12'h001;
    end
  end

  // Stage one: raw pair plus the delayed word
  logic  s1v_ff;
  logic  s1dir_ff;
  logic  s1zero_ff;
  pair_s s1_ff;
  pair_s s1_out;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1v_ff    <= 1'b0;
      s1dir_ff  <= DIR_RST;
      s1zero_ff <= 1'b1;
      s1_ff     <= '0;
    end else begin
      s1v_ff <= take;
      if (take) begin
        s1dir_ff  <= dir_ff;
        s1zero_ff <= (len_ff == 12'h000);
        s1_ff     <= in_pair;
      end
    end
  end

  always_comb begin
    s1_out = s1_ff;
    if (!s1zero_ff) begin
      if (s1dir_ff) begin
        s1_out.mic_s = rd_ff;
      end else begin
        s1_out.ref_s = rd_ff;
      end
    end
  end

  // Two-entry output buffer; stage one counts as occupancy
  pair_s      e0_ff;
  pair_s      e1_ff;
  logic [1:0] cnt_ff;
  logic       rdy_ff;
  logic       ov_ff;
  logic       pop;
  logic [1:0] cnt_pop;
  logic [1:0] nxt_cnt;
  logic [1:0] nxt_occ;
  assign pop     = (cnt_ff != 2'h0) & out_ready;
  assign cnt_pop = cnt_ff - {1'b0, pop};
  assign nxt_cnt = cnt_pop + {1'b0, s1v_ff};
  assign nxt_occ = nxt_cnt + {1'b0, take};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 2'h0;
      rdy_ff <= 1'b0;
      ov_ff  <= 1'b0;
      e0_ff  <= '0;
      e1_ff  <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      rdy_ff <= (nxt_occ < 2'h2);
      // Registered copy so the valid pin leaves a flop
      ov_ff  <= (nxt_cnt != 2'h0);
      if (pop) begin
        e0_ff <= e1_ff;
      end
      if (s1v_ff) begin
        if (cnt_pop == 2'h0) begin
          e0_ff <= s1_out;
        end else begin
          e1_ff <= s1_out;
        end
      end
    end
  end

  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign in_ready     = rdy_ff;
  assign out_valid    = ov_ff;
  assign out_pair     = e0_ff;
  assign ec_cancel_en = cancel_ff;
  assign ec_restart   = restart_ff;
  assign ec_adapt_cfg = ec_adapt_ff;

  a_len_bounded: assert property (@(posedge pclk) disable iff (!presetn)
    len_ff <= DLY_MAX) else $error("delay length above limit");
  a_cancel_off: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_EST) |-> !ec_cancel_en && active_ff) else $error("cancel on in estimate");
  a_restart_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_APPLY) |=> ec_restart ##1 !ec_restart) else $error("no restart");
  a_force_start: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_force && state_ff == ST_IDLE) |-> ##[1:2] (state_ff == ST_EST))
    else $error("trigger ignored");
  a_gate_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_IDLE && !force_pend_ff && !gate_ok) |=> (state_ff == ST_IDLE))
    else $error("start without reference");
  a_auto_lock: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && auto_en_ff && paddr == OFF_LEN && state_ff == ST_IDLE) |=> $stable(len_ff))
    else $error("host length write took effect");
  a_apply_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_APPLY) |=> (dir_ff == (est_ff < EST_OFFSET)))
    else $error("wrong delay direction");
  a_est_bound: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_EST) |-> (timer_ff < EST_TIMEOUT_CYC)) else $error("estimate overran");
  a_adapt_own: assert property (@(posedge pclk) disable iff (!presetn)
    (auto_en_ff && $past(auto_en_ff)) |-> (ec_adapt_cfg == ADAPT_AUTO))
    else $error("adaptation not owned");
  a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && paddr == OFF_EST && !active_ff) |=> (prdata == 32'h0000_0000))
    else $error("estimate visible outside cycle");
endmodule

/* ec_model.sv */
// Purpose: Echo canceller stand-in answering delay estimation cycles
// Assumes: Estimate and answer latency are set by the bench
// Notes:   A latency past the block timeout leaves a cycle unanswered
`timescale 1ns/1ps
module ec_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bench control
  input  wire logic [12:0] est_val,
  input  wire logic [7:0]  lat,
  // Echo canceller link
  input  wire logic        ec_cancel_en,
  output logic             ec_est_valid,
  output logic [12:0]      ec_est,
  output logic             ec_est_done
);
  logic [8:0] cnt_ff;

  // Estimate at lat, done at twice lat; bus toggles when not qualified
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff       <= 9'h000;
      ec_est_valid <= 1'b0;
      ec_est_done  <= 1'b0;
      ec_est       <= 13'h0000;
    end else begin
      cnt_ff       <= ec_cancel_en ? 9'h000 : cnt_ff + 9'h001;
      ec_est_valid <= !ec_cancel_en && cnt_ff == {1'b0, lat};
      ec_est_done  <= !ec_cancel_en && cnt_ff == {lat, 1'b0};
      ec_est       <= (!ec_cancel_en && cnt_ff == {1'b0, lat}) ? est_val : ~ec_est;
    end
  end
endmodule

/* tb_top.sv */
// Purpose: Self-checking bench for the delay alignment stage
// Assumes: Estimation timeout shortened to 50 cycles
// Notes:   Sink stalls at random to exercise the output buffer
`timescale 1ns/1ps
module tb_top;
  import align_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        in_valid, in_ready, out_valid, out_ready, host_cfg_change, spk_playing;
  logic        ec_est_valid, ec_est_done, ec_cancel_en, ec_restart;
  logic [7:0]  paddr, lat;
  logic [31:0] pwdata, prdata, r;
  logic [12:0] ec_est, est_val, prev;
  logic [1:0]  ec_adapt_cfg;
  pair_s       in_pair, out_pair;
  pair_s       inq[$], outq[$];
  int          num_errors, checked, i, len, n_rst;
  logic [12:0] te[5] = '{13'h9C4, 13'h92E, 13'h1C20, 13'h000, 13'h064};
  logic [7:0]  tl[5] = '{8'h0C, 8'h14, 8'h0E, 8'h0A, 8'h50};

  auto_delay_alignment #(.EST_TIMEOUT_CYC(50)) auto_delay_alignment_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .in_valid,
    .in_pair, .in_ready, .out_valid, .out_pair, .out_ready, .host_cfg_change, .spk_playing,
    .ec_est_valid, .ec_est, .ec_est_done, .ec_cancel_en, .ec_restart, .ec_adapt_cfg);
  ec_model ec_model_i (.pclk, .presetn, .est_val, .lat, .ec_cancel_en, .ec_est_valid,
    .ec_est, .ec_est_done);

  always #25 pclk = ~pclk;

  always @(posedge pclk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) outq.push_back(out_pair);
    out_ready <= 1'($urandom_range(3) != 0);
    if (ec_restart === 1'b1) n_rst <= n_rst + 1;
  end

  function automatic logic [31:0] exp_p(int j, int n, logic dir);
    pair_s e;
    e = inq[j];
    if (dir) e.mic_s = inq[j - n].mic_s;
    else e.ref_s = inq[j - n].ref_s;
    return e;
  endfunction

  // Direction in bit 12, length below
  function automatic logic [12:0] exp_ld(logic [12:0] e);
    int d;
    d = int'(e) - int'(EST_OFFSET);
    if (d < 0) return {1'b1, 12'(-d > int'(DLY_MAX) ? int'(DLY_MAX) : -d)};
    return {1'b0, 12'(d > int'(DLY_MAX) ? int'(DLY_MAX) : d)};
  endfunction

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", n, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("Checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic hang(input string n);
    num_errors++;
    $display("[ERR] %s expected answer seen none", n);
    test_done();
  endtask

  task automatic ws(ref logic s, input logic v, input int lim);
    int k;
    for (k = 0; k < lim && s !== v; k++) @(posedge pclk);
    if (k == lim) hang("wait");
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
    if (k == 20) hang("pready");
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, r, exp);
  endtask

  // Loud reference samples open the estimation gate
  task automatic send(input int n, input logic loud, input int dl, input logic dir);
    int k, j;
    pair_s p;
    inq.delete();
    outq.delete();
    @(posedge pclk);
    for (j = 0; j < n; j++) begin
      p.ref_s = loud ? 16'hC000 : 16'($urandom_range(255));
      p.mic_s = 16'($urandom);
      inq.push_back(p);
      in_valid <= 1'b1;
      in_pair <= p;
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (in_ready !== 1'b1 && k < 50);
      if (k == 50) hang("in_ready");
    end
    in_valid <= 1'b0;
    for (k = 0; k < 200 && outq.size() < n; k++) @(posedge pclk);
    for (j = dl; j < n; j++) chk("pair", outq[j], exp_p(j, dl, dir));
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, in_valid, out_ready, host_cfg_change} = '0;
    spk_playing = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    in_pair = '0;
    est_val = 13'h970;
    lat = 8'h0A;
    void'($urandom(22));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CTRL, 32'h2, "ctrl");
    rd(OFF_DIR, 32'h0, "dir");
    rd(OFF_STATUS, 32'h0, "status");
    rd(OFF_EST, 32'h0, "est");
    rd(8'h18, 32'h0, "unmapped");
    chk("slverr", err, 32'h1);
    $display("Reset test done");
    spk_playing <= 1'b1;
    send(12, 1'b0, 0, 1'b0);
    rd(OFF_STATUS, 32'h0, "quiet");
    spk_playing <= 1'b0;
    send(4, 1'b1, 0, 1'b0);
    rd(OFF_STATUS, 32'h0, "silent");
    spk_playing <= 1'b1;
    ws(ec_cancel_en, 1'b0, 4);
    rd(OFF_STATUS, 32'h1, "startup");
    ws(ec_cancel_en, 1'b1, 100);
    rd(OFF_LEN, 32'h010, "startup_len");
    repeat (20) @(posedge pclk);
    chk("once", ec_cancel_en, 32'h1);
    $display("Startup test done");
    apb(1'b1, OFF_LEN, 32'hFFF);
    rd(OFF_LEN, 32'h95F, "clamp");
    for (i = 0; i < 2; i++) begin
      len = 1 + $urandom_range(5);
      apb(1'b1, OFF_LEN, len);
      apb(1'b1, OFF_DIR, i);
      rd(OFF_DIR, i, "dir_rw");
      send(16, 1'b0, len, i[0]);
    end
    prev = {1'b1, 12'(len)};
    $display("Delay test done");
    for (i = 0; i < 5; i++) begin
      est_val <= te[i];
      lat <= tl[i];
      apb(1'b1, OFF_CTRL, 32'h4);
      ws(ec_cancel_en, 1'b0, 3);
      rd(OFF_STATUS, 32'h1, "active");
      if (tl[i] < 8'h32) begin
        ws(ec_est_valid, 1'b1, 40);
        rd(OFF_EST, te[i], "est_live");
        prev = exp_ld(te[i]);
      end
      ws(ec_cancel_en, 1'b1, 120);
      chk("restart", n_rst, i + 2);
      rd(OFF_LEN, prev[11:0], "len");
      rd(OFF_DIR, prev[12], "dir");
    end
    $display("Estimation test done");
    apb(1'b1, OFF_ADAPT, 32'h2);
    rd(OFF_ADAPT, 32'h2, "adapt_rw");
    chk("adapt_host", ec_adapt_cfg, 32'h2);
    apb(1'b1, OFF_CTRL, 32'h1);
    rd(OFF_CTRL, 32'h1, "auto");
    chk("adapt_auto", ec_adapt_cfg, ADAPT_AUTO);
    rd(OFF_ADAPT, 32'h2, "adapt_rd");
    apb(1'b1, OFF_LEN, 32'h5);
    rd(OFF_LEN, prev[11:0], "len_locked");
    send(2, 1'b1, 2, prev[12]);
    est_val <= 13'h96A;
    lat <= 8'h0A;
    host_cfg_change <= 1'b1;
    @(posedge pclk);
    host_cfg_change <= 1'b0;
    ws(ec_cancel_en, 1'b0, 4);
    ws(ec_cancel_en, 1'b1, 100);
    rd(OFF_LEN, 32'h00A, "auto_len");
    rd(OFF_DIR, 32'h0, "auto_dir");
    apb(1'b1, OFF_CTRL, 32'h0);
    host_cfg_change <= 1'b1;
    @(posedge pclk);
    host_cfg_change <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("cfg_ignored", ec_cancel_en, 32'h1);
    $display("Auto test done");
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h0);
    send(4, 1'b1, 0, 1'b0);
    repeat (5) @(posedge pclk);
    chk("no_startup", ec_cancel_en, 32'h1);
    $display("Restart test done");
    test_done();
  end
endmodule
